// [rtl/qsx_master.sv]
// Quad serial flash master with execute-in-place path, and its byte FIFO.
// Assumes AHB-lite on clk_sys_i; control bits arrive as plain ports.
`timescale 1ns/10ps
`default_nettype none

module qsx_fifo
    import qsx_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
            $error("qsx_fifo: depth must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    wire logic full = (wptr ^ rptr) == {1'b1, {AW{1'b0}}};
    wire logic empty = wptr == rptr;
    wire logic do_push = in_valid_i & ~full;
    wire logic do_pop = out_ready_i & ~empty;
    assign in_ready_o = ~full;
    assign out_valid_o = ~empty;
    assign out_data_o = mem[rptr[AW-1:0]];
    always_ff @(posedge clk_sys_i)
    begin
        if (do_push)
            mem[wptr[AW-1:0]] <= in_data_i;
    end
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            wptr <= '0;
            rptr <= '0;
        end
        else
        begin
            wptr <= wptr + (AW+1)'(do_push);
            rptr <= rptr + (AW+1)'(do_pop);
        end
    end
    full_depth_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !in_ready_o |-> (wptr - rptr) == (AW+1)'(DEPTH))
        else $error("fifo refuses before holding its full depth");
endmodule

// Function
// - Acts only as bus master; drives serial clock and select itself.
// - Serial clock is the system clock divided by two, four or six.
// - Outgoing bytes buffer 16 deep, incoming bytes 32 deep.
// - Data writes push the transmit FIFO; data reads pop the receive FIFO.
// - Each data-register access moves one to four bytes.
// - Two mode inputs pick extended, dual or quad lane use.
// - Flash addresses go out as three or four bytes.
// - Frames are eight bits; longer transfers run frames with no gap.
// - Transmit underrun and receive overflow are recorded as status.
// - Frames are counted and completion of the programmed count flagged.
// - The execute-in-place enable places the block in that mode.
// - Fetch: address bytes, three idle bytes, four data bytes, one word.
// - Fetched data goes straight to the bus, never via the FIFO.
// - Execute-in-place holds while the hold bit stays zero.
// - In that mode writes still land; register reads are unavailable.
// - Reset does not clear execute-in-place; the enable is a plain input.
// - Clearing the enable returns reads to the registers.
// - Direct mode lets software drive and sample the pins.
// - Select level after normal transfers is configurable.
// - Filler bytes are sent and unwanted received bytes dropped.
module qsx_master
    import qsx_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    input wire logic xip_enable_i,
    input wire logic xip_hold_bit_i,
    input wire logic lane_mode_bit_low_i,
    input wire logic [1:0] lane_mode_bits_high_i,
    input wire logic [1:0] serial_clock_divider_i,
    input wire logic addr_four_bytes_i,
    input wire logic ss_keep_idle_i,
    input wire logic [15:0] frame_count_i,
    input wire logic [15:0] tx_frames_i,
    input wire logic [15:0] rx_skip_i,
    input wire logic start_i,
    input wire logic status_clear_i,
    input wire logic direct_mode_i,
    input wire qsx_pins_type direct_pins_i,
    input wire logic [3:0] io_in_i,
    output qsx_pins_type pins_o,
    output logic [3:0] io_sampled_o,
    output qsx_status_type status_o,
    output logic done_o
);
    function automatic logic [2:0] lanes_f(input logic quad,
        input logic [1:0] high, input logic first);
        if (quad)
            return 3'h4;
        case (high)
            LANE_DUAL: return 3'h2;
            LANE_EXT_2: return first ? 3'h1 : 3'h2;
            LANE_EXT_4: return first ? 3'h1 : 3'h4;
            default: return 3'h1;
        endcase
    endfunction

    function automatic logic [3:0] steps_f(input logic [2:0] lanes);
        return (lanes == 3'h4) ? 4'h2 : (lanes == 3'h2) ? 4'h4 : 4'h8;
    endfunction

    qsx_eng_type eng;
    qsx_ahb_type ast;
    logic [3:0] io_meta;
    logic [3:0] io_s;
    logic [1:0] divcnt;
    logic sck;
    logic ss_n;
    logic [15:0] frame;
    logic [15:0] rframe;
    logic [15:0] total;
    logic [15:0] txcnt;
    logic [15:0] skip;
    logic is_xip;
    logic [2:0] lanes;
    logic drive;
    logic [7:0] txsh;
    logic [7:0] rxsh;
    logic [3:0] bitcnt;
    logic [3:0] rbits;
    logic samp;
    logic [31:0] xip_addr;
    logic [31:0] xip_word;
    logic [2:0] alen;
    logic underrun;
    logic overflow;
    logic [2:0] bcnt;
    logic [1:0] lane_idx;
    logic [31:0] wbuf;
    logic xip_start;
    logic is_xip_pend_done;

    // Both pipe stages keep metastable pin levels away from the shift logic.
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            io_meta <= '0;
            io_s <= '0;
        end
        else
        begin
            io_meta <= io_in_i;
            io_s <= io_meta;
        end
    end

    wire logic xip_active = xip_enable_i & ~xip_hold_bit_i;
    wire logic [1:0] half = (serial_clock_divider_i == DIV_BY_6) ? 2'h3 :
        (serial_clock_divider_i == DIV_BY_4) ? 2'h2 : 2'h1;
    wire logic tick = (eng == ENG_SHIFT) && (divcnt == half - 2'h1);
    wire logic fall = tick & sck;
    wire logic [3:0] steps = steps_f(lanes);
    wire logic frame_end = fall && (bitcnt == steps);
    wire logic [15:0] frame_nx = (eng == ENG_LOAD) ? 16'h0 : frame + 16'h1;
    wire logic last = frame_nx == total;
    wire logic load_evt = (eng == ENG_LOAD) | (frame_end & ~last);
    wire logic out_nx = frame_nx < txcnt;
    wire logic [2:0] lanes_nx = lanes_f(lane_mode_bit_low_i,
        lane_mode_bits_high_i, frame_nx == 16'h0);
    wire logic [1:0] abi = 2'(alen - 3'h1 - frame_nx[2:0]);
    wire logic [7:0] addr_byte = xip_addr[{abi, 3'b000} +: 8];
    wire logic tx_valid;
    wire logic [7:0] tx_data;
    wire logic tx_pop = load_evt & ~is_xip & out_nx & tx_valid;
    wire logic underrun_evt = load_evt & ~is_xip & out_nx & ~tx_valid;
    wire logic [7:0] next_txsh = is_xip ?
        (out_nx ? addr_byte : XIP_IDLE_BYTE) :
        (tx_pop ? tx_data : FILLER_BYTE);

    // Receive side runs one cycle behind each falling edge, after the pin
    // pipe, so the sampled bit is the one the flash held across the rise.
    wire logic [2:0] rlanes = lanes_f(lane_mode_bit_low_i,
        lane_mode_bits_high_i, rframe == 16'h0);
    wire logic [7:0] rx_next = (rlanes == 3'h4) ? {rxsh[3:0], io_s} :
        (rlanes == 3'h2) ? {rxsh[5:0], io_s[1:0]} : {rxsh[6:0], io_s[1]};
    wire logic rx_done = samp && (rbits + 4'h1 == steps_f(rlanes));
    wire logic rx_last = rframe + 16'h1 == total;
    wire logic rx_keep = rx_done & ~is_xip & (rframe >= skip);
    wire logic rx_ready;
    wire logic rx_push = rx_keep & rx_ready;
    wire logic overflow_evt = rx_keep & ~rx_ready;
    wire logic xip_byte = rx_done & is_xip &
        (rframe >= 16'(alen) + XIP_IDLE_FRAMES);
    wire logic [31:0] xip_word_nx = {rx_next, xip_word[31:8]};
    wire logic xip_done = rx_done & is_xip & rx_last;
    wire logic busy = (eng != ENG_IDLE) | samp;
    wire logic norm_start = start_i & ~busy & ~xip_active &
        (frame_count_i != 16'h0);

    // Engine: start, frame load and bit shifting.
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            eng <= ENG_IDLE;
            frame <= '0;
            total <= '0;
            txcnt <= '0;
            skip <= '0;
            is_xip <= 1'b0;
            lanes <= 3'h1;
            drive <= 1'b0;
            txsh <= '0;
            bitcnt <= '0;
            divcnt <= '0;
            sck <= 1'b0;
        end
        else
        begin
            case (eng)
                ENG_IDLE:
                begin
                    if (xip_start)
                    begin
                        eng <= ENG_LOAD;
                        is_xip <= 1'b1;
                        total <= 16'(alen) + XIP_IDLE_FRAMES +
                            XIP_DATA_FRAMES;
                        txcnt <= 16'(alen);
                        skip <= '0;
                    end
                    else if (norm_start)
                    begin
                        eng <= ENG_LOAD;
                        is_xip <= 1'b0;
                        total <= frame_count_i;
                        txcnt <= tx_frames_i;
                        skip <= rx_skip_i;
                    end
                end
                ENG_LOAD:
                    eng <= ENG_SHIFT;
                ENG_SHIFT:
                begin
                    divcnt <= tick ? 2'h0 : divcnt + 2'h1;
                    if (tick)
                        sck <= ~sck;
                    if (tick & ~sck)
                        bitcnt <= bitcnt + 4'h1;
                    else if (fall)
                        txsh <= txsh << lanes;
                    if (frame_end & last)
                        eng <= ENG_IDLE;
                end
                default:
                    eng <= ENG_IDLE;
            endcase
            if (load_evt)
            begin
                frame <= frame_nx;
                txsh <= next_txsh;
                lanes <= lanes_nx;
                drive <= out_nx;
                bitcnt <= '0;
            end
        end
    end

    // Select goes low at load and, if asked, stays low after a normal transfer; a fetch always releases it.
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
            ss_n <= 1'b1;
        else if (eng == ENG_LOAD)
            ss_n <= 1'b0;
        else if (frame_end & last)
            ss_n <= is_xip | ~ss_keep_idle_i;
        else if (eng == ENG_IDLE & ~ss_keep_idle_i)
            ss_n <= 1'b1;
    end

    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            samp <= 1'b0;
            rxsh <= '0;
            rbits <= '0;
            rframe <= '0;
            xip_word <= '0;
            done_o <= 1'b0;
        end
        else
        begin
            samp <= fall;
            done_o <= rx_done & rx_last & ~is_xip;
            if (eng == ENG_LOAD)
            begin
                rframe <= '0;
                rbits <= '0;
            end
            else if (samp)
            begin
                rxsh <= rx_next;
                rbits <= rx_done ? 4'h0 : rbits + 4'h1;
                if (rx_done)
                    rframe <= rframe + 16'h1;
            end
            if (xip_byte)
                xip_word <= xip_word_nx;
        end
    end

    // Hardware set wins over a clear in the same cycle.
    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            underrun <= 1'b0;
            overflow <= 1'b0;
        end
        else
        begin
            underrun <= underrun_evt | (underrun & ~status_clear_i);
            overflow <= overflow_evt | (overflow & ~status_clear_i);
        end
    end

    // AHB side. Only one byte moves per cycle, so wider accesses wait.
    wire logic a_take = hsel_i & htrans_i[1] & hready_i &
        (ast == AHB_IDLE);
    wire logic [3:0] a_reg = haddr_i[3:0];
    wire logic [2:0] a_bytes = (hsize_i == 3'h0) ? 3'h1 :
        (hsize_i == 3'h1) ? 3'h2 : 3'h4;
    wire logic push_ok = (ast == AHB_PUSH);
    wire logic tx_ready;
    wire logic tx_push = push_ok & tx_ready;
    wire logic [7:0] push_byte = wbuf[{lane_idx, 3'b000} +: 8];
    wire logic rx_valid;
    wire logic [7:0] rx_data;
    wire logic rx_pop = (ast == AHB_POP) & rx_valid;
    assign xip_start = (ast == AHB_XIP) & (eng == ENG_IDLE) & ~samp &
        ~is_xip_pend_done;

    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ast <= AHB_IDLE;
            bcnt <= '0;
            lane_idx <= '0;
            wbuf <= '0;
            xip_addr <= '0;
            alen <= 3'h3;
            hrdata_o <= '0;
            is_xip_pend_done <= 1'b0;
        end
        else
        begin
            case (ast)
                AHB_IDLE:
                begin
                    lane_idx <= haddr_i[1:0];
                    bcnt <= a_bytes;
                    if (a_take & ~hwrite_i & xip_active)
                    begin
                        ast <= AHB_XIP;
                        xip_addr <= haddr_i;
                        alen <= addr_four_bytes_i ? 3'h4 : 3'h3;
                        is_xip_pend_done <= 1'b0;
                    end
                    else if (a_take & hwrite_i & (a_reg == OFS_TX_DATA))
                        ast <= AHB_WDATA;
                    else if (a_take & ~hwrite_i & (a_reg == OFS_RX_DATA))
                    begin
                        ast <= AHB_POP;
                        hrdata_o <= '0;
                    end
                end
                AHB_WDATA:
                begin
                    wbuf <= hwdata_i;
                    ast <= AHB_PUSH;
                end
                AHB_PUSH:
                begin
                    if (tx_ready)
                    begin
                        lane_idx <= lane_idx + 2'h1;
                        bcnt <= bcnt - 3'h1;
                        if (bcnt == 3'h1)
                            ast <= AHB_IDLE;
                    end
                end
                AHB_POP:
                begin
                    if (rx_valid)
                        hrdata_o[{lane_idx, 3'b000} +: 8] <= rx_data;
                    lane_idx <= lane_idx + 2'h1;
                    bcnt <= bcnt - 3'h1;
                    if (bcnt == 3'h1)
                        ast <= AHB_IDLE;
                end
                AHB_XIP:
                begin
                    if (xip_start)
                        is_xip_pend_done <= 1'b1;
                    if (xip_done)
                    begin
                        hrdata_o <= xip_word_nx;
                        ast <= AHB_IDLE;
                    end
                end
                default:
                    ast <= AHB_IDLE;
            endcase
        end
    end

    assign hreadyout_o = (ast == AHB_IDLE);
    assign hresp_o = 1'b0;

    qsx_fifo #(
        .WIDTH(8),
        .DEPTH(TX_DEPTH)
    ) u_tx_fifo (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .in_valid_i(tx_push),
        .in_ready_o(tx_ready),
        .in_data_i(push_byte),
        .out_valid_o(tx_valid),
        .out_ready_i(tx_pop),
        .out_data_o(tx_data)
    );

    qsx_fifo #(
        .WIDTH(8),
        .DEPTH(RX_DEPTH)
    ) u_rx_fifo (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .in_valid_i(rx_push),
        .in_ready_o(rx_ready),
        .in_data_i(rx_next),
        .out_valid_o(rx_valid),
        .out_ready_i(rx_pop),
        .out_data_o(rx_data)
    );

    wire logic [3:0] eng_oe = (lanes == 3'h4) ? {4{drive}} :
        (lanes == 3'h2) ? {2'b00, {2{drive}}} : 4'h1;
    wire logic [3:0] eng_out = (lanes == 3'h4) ? txsh[7:4] :
        (lanes == 3'h2) ? {2'b00, txsh[7:6]} : {3'b000, txsh[7]};
    wire qsx_pins_type eng_pins = '{sck: sck, ss_n: ss_n,
        io_out: eng_out, io_oe: (eng == ENG_IDLE) ? 4'h0 : eng_oe};
    assign pins_o = direct_mode_i ? direct_pins_i : eng_pins;
    assign io_sampled_o = io_s;
    assign status_o = '{tx_underrun: underrun, rx_overflow: overflow,
        busy: busy, xip_active: xip_active};

    master_clock_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !direct_mode_i && pins_o.sck |-> !pins_o.ss_n)
        else $error("serial clock moved with select released");
    div_four_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        serial_clock_divider_i == DIV_BY_4 && $stable(serial_clock_divider_i)
        && $rose(sck) |-> sck ##1 sck)
        else $error("divide by four high phase not two cycles");
    no_gap_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        frame_end && !last |=> eng == ENG_SHIFT && !sck && !ss_n)
        else $error("gap between back to back frames");
    underrun_flag_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        underrun_evt |=> status_o.tx_underrun)
        else $error("underrun not recorded");
    overflow_flag_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        overflow_evt |=> status_o.rx_overflow)
        else $error("overflow not recorded");
    xip_frames_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        xip_start |=> total == 16'(alen) + 16'h0007 && txcnt == 16'(alen))
        else $error("fetch frame count wrong");
    fetch_return_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        xip_done |=> hreadyout_o && hrdata_o == $past(xip_word_nx))
        else $error("fetched word not returned");
    fetch_wait_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $rose(ast == AHB_XIP) |-> !hreadyout_o ##1 !hreadyout_o)
        else $error("fetch completed without waiting");
    push_bytes_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        a_take && hwrite_i && a_reg == OFS_TX_DATA && hsize_i == 3'h2
        |=> ##1 push_ok [*4])
        else $error("word write did not push four bytes");
    xip_off_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !xip_enable_i |-> !status_o.xip_active)
        else $error("execute-in-place active while disabled");
endmodule

`default_nettype wire

// [rtl/qsx_pkg.sv]
// Shared constants and types of the quad serial flash master.
// Assumes a single system clock; control bits come as ports, not over the bus.
`default_nettype none
package qsx_pkg;
    localparam int TX_DEPTH = 16;
    localparam int RX_DEPTH = 32;
    localparam logic [3:0] OFS_TX_DATA = 4'h0;
    localparam logic [3:0] OFS_RX_DATA = 4'h4;
    localparam logic [7:0] FILLER_BYTE = 8'hFF;
    localparam logic [7:0] XIP_IDLE_BYTE = 8'hFF;
    localparam logic [15:0] XIP_IDLE_FRAMES = 16'h0003;
    localparam logic [15:0] XIP_DATA_FRAMES = 16'h0004;
    localparam logic [1:0] DIV_BY_2 = 2'h0;
    localparam logic [1:0] DIV_BY_4 = 2'h1;
    localparam logic [1:0] DIV_BY_6 = 2'h2;
    localparam logic [1:0] LANE_EXT_1 = 2'h0;
    localparam logic [1:0] LANE_EXT_2 = 2'h1;
    localparam logic [1:0] LANE_EXT_4 = 2'h2;
    localparam logic [1:0] LANE_DUAL = 2'h3;
    typedef enum logic [1:0] {
        ENG_IDLE = 2'b00,
        ENG_LOAD = 2'b01,
        ENG_SHIFT = 2'b11
    } qsx_eng_type;
    typedef enum logic [2:0] {
        AHB_IDLE = 3'b000,
        AHB_WDATA = 3'b001,
        AHB_PUSH = 3'b011,
        AHB_POP = 3'b010,
        AHB_XIP = 3'b110
    } qsx_ahb_type;
    typedef struct packed {
        logic sck;
        logic ss_n;
        logic [3:0] io_out;
        logic [3:0] io_oe;
    } qsx_pins_type;
    typedef struct packed {
        logic tx_underrun;
        logic rx_overflow;
        logic busy;
        logic xip_active;
    } qsx_status_type;
endpackage
`default_nettype wire

// [tb/qsx_flash_model.sv]
// Behavioural serial flash on one lane: command-free fetch of 3 address
// bytes, 3 idle bytes, then data byte k = address low byte plus k.
`timescale 1ns/10ps
`default_nettype none
module qsx_flash_model
(
    input wire logic sck_i,
    input wire logic ss_n_i,
    input wire logic io0_i,
    output logic io1_o,
    output logic [23:0] addr_o
);
    int cnt = 0;
    logic [7:0] data;
    initial io1_o = 1'b0;
    initial addr_o = 24'h0;
    always @(posedge ss_n_i) cnt <= 0;
    always @(posedge sck_i)
        if (!ss_n_i)
        begin
            if (cnt < 24)
                addr_o <= {addr_o[22:0], io0_i};
            cnt <= cnt + 1;
        end
    // Released line shows the inverse so stale data never looks valid.
    always @(negedge sck_i or posedge ss_n_i)
        if (ss_n_i)
            io1_o <= ~io1_o;
        else if (cnt >= 48)
        begin
            data = addr_o[7:0] + 8'((cnt - 48) / 8);
            io1_o <= data[7 - (cnt - 48) % 8];
        end
        else
            io1_o <= 1'b0;
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench of the quad serial flash master.
// Assumes the single-lane flash model sits on the serial pins.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin \
err_total++; $display("MISMATCH %0t %s", $time, m); end end
module tb
    import qsx_pkg::*;
;
    typedef struct {logic [1:0] dv; int nd; logic [31:0] a, w;} qsx_row_type;
    qsx_row_type rows [4] = '{'{DIV_BY_2, 2, 32'h100, 32'h03020100},
        '{DIV_BY_4, 4, 32'h2A4, 32'hA7A6A5A4},
        '{DIV_BY_6, 6, 32'hFFFFFC, 32'hFFFEFDFC},
        '{2'h3, 2, 32'h55, 32'h58575655}};
    logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0, dv = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic xen = 1'b0, hold = 1'b0, start = 1'b0, sclr = 1'b0, dm = 1'b0;
    logic [15:0] fc = 16'h0, txf = 16'h0, rxs = 16'h0;
    qsx_pins_type dp = '0, pins;
    qsx_status_type st;
    logic hrdy, hresp, done, fl_io1;
    logic [3:0] io_samp;
    logic [23:0] fl_addr;
    int err_total = 0, compares = 0, cyc = 0, sel_cnt = 0, n = 0, s0 = 0;
    qsx_master qsx_master_i (.clk_sys_i(clk), .reset_i(rst), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(1'b1),
        .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata),
        .xip_enable_i(xen), .xip_hold_bit_i(hold),
        .lane_mode_bit_low_i(1'b0), .lane_mode_bits_high_i(2'h0),
        .serial_clock_divider_i(dv), .addr_four_bytes_i(1'b0),
        .ss_keep_idle_i(1'b0), .frame_count_i(fc), .tx_frames_i(txf),
        .rx_skip_i(rxs), .start_i(start), .status_clear_i(sclr),
        .direct_mode_i(dm), .direct_pins_i(dp),
        .io_in_i({2'b10, fl_io1, 1'b1}), .pins_o(pins),
        .io_sampled_o(io_samp), .status_o(st), .done_o(done));
    qsx_flash_model qsx_flash_model_i (.sck_i(pins.sck), .ss_n_i(pins.ss_n),
        .io0_i(pins.io_out[0]), .io1_o(fl_io1), .addr_o(fl_addr));
    always #25 clk = ~clk;
    always @(negedge pins.ss_n) sel_cnt++;
    task automatic end_sim();
        if (err_total == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Request held from one edge to the next; data phase waits on ready.
    task automatic ahb(input logic [31:0] a, input logic w,
        input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end while (hrdy !== 1'b1 && n < 2000);
        rd = hrdata;
        `CHK(hrdy, 1'b1, "ready")
        `CHK(hresp, 1'b0, "response")
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            err_total++;
            end_sim();
        end
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        `CHK({hrdy, pins.ss_n, pins.sck, pins.io_oe}, 7'h60, "idle")
        `CHK({st, done}, 5'h0, "status at reset")
        @(posedge clk);
        xen <= 1'b1;
        foreach (rows[i])
        begin
            @(posedge clk);
            dv <= rows[i].dv;
            ahb(rows[i].a, 1'b0, 32'h0);
            `CHK(rd, rows[i].w, "fetch word")
            `CHK(fl_addr, rows[i].a[23:0], "fetch address")
            `CHK(n > 76 * rows[i].nd && n < 84 * rows[i].nd + 8, 1'b1,
                "fetch length")
        end
        s0 = sel_cnt;
        hold <= 1'b1;
        ahb(32'h4, 1'b0, 32'h0);
        `CHK(sel_cnt, s0, "hold read went to flash")
        hold <= 1'b0;
        // Leave the mode only once no fetch is outstanding.
        xen <= 1'b0;
        ahb(32'h0, 1'b1, 32'h44332211);
        ahb(32'h4, 1'b0, 32'h0);
        `CHK({sel_cnt, rd}, {s0, 32'h0}, "register read")
        fc <= 16'h5;
        txf <= 16'h5;
        rxs <= 16'h1;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end while (done !== 1'b1 && n < 1000);
        `CHK(done, 1'b1, "done pulse")
        `CHK(fl_addr, 24'h112233, "pushed bytes")
        `CHK(st.tx_underrun, 1'b1, "underrun flag")
        @(posedge clk);
        sclr <= 1'b1;
        @(posedge clk);
        sclr <= 1'b0;
        @(posedge clk);
        #1;
        `CHK(st.tx_underrun, 1'b0, "flag clear")
        ahb(32'h4, 1'b0, 32'h0);
        `CHK(rd, 32'h0, "popped bytes")
        @(posedge clk);
        dm <= 1'b1;
        dp <= '{sck: 1'b1, ss_n: 1'b0, io_out: 4'hA, io_oe: 4'h5};
        repeat (3) @(posedge clk);
        #1;
        `CHK(pins, dp, "direct pins")
        `CHK(io_samp[3:2], 2'b10, "sampled pins")
        end_sim();
    end
endmodule
`default_nettype wire
